//--- dac_pkg.sv
`default_nettype none
package dac_pkg;
  // Converter word.
  localparam int WORD_BITS     = 12;
  localparam int FULL_SCALE_MV = 4095;
  localparam int MV_PER_LSB    = 1;
  localparam logic [WORD_BITS-1:0] DAC_RESET_CODE = 12'h000;

  // Host clock and minimum pin timings.
  localparam int CLK_PERIOD_NS  = 50;
  localparam int T_CLK_HIGH_NS  = 30;
  localparam int T_CLK_LOW_NS   = 30;
  localparam int T_SELECT_NS    = 30;
  localparam int T_DESELECT_NS  = 20;
  localparam int T_LOAD_NS      = 20;
  localparam int T_CLEAR_NS     = 30;

  // Minimum times round up to whole cycles, never below one.
  localparam int CLK_HIGH_CYC = (T_CLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                (T_CLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_LOW_CYC  = (T_CLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                (T_CLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_CYC   = (T_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                (T_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DESELECT_CYC = (T_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                (T_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_CYC     = (T_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                (T_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_CYC    = (T_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                (T_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host sequencer states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_SELECT   = 7'h02,
    ST_LOW      = 7'h04,
    ST_HIGH     = 7'h08,
    ST_DESELECT = 7'h10,
    ST_LOAD     = 7'h20,
    ST_CLEAR    = 7'h40
  } host_state_t;
endpackage : dac_pkg
`default_nettype wire

//--- dac_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dac_link_if;
  logic sclk;
  logic serial_data_in;
  logic chip_select_n;
  logic load_strobe_n;
  logic clear_n;

  modport host (
    output sclk,
    output serial_data_in,
    output chip_select_n,
    output load_strobe_n,
    output clear_n
  );

  modport device (
    input sclk,
    input serial_data_in,
    input chip_select_n,
    input load_strobe_n,
    input clear_n
  );
endinterface : dac_link_if
`default_nettype wire

//--- word_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module word_buffer #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             reset,
  // Filling side.
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Draining side.
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = DEPTH > 1 ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("word_buffer: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;
  logic [AW:0]      nxt_count;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign out_valid = count_ff != '0;

  // Storage and pointers; flags follow the count so full stalls the source.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      in_ready  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + AW'(1);
      end
      count_ff <= nxt_count;
      in_ready <= nxt_count != (AW+1)'(DEPTH);
    end
  end
endmodule : word_buffer
`default_nettype wire

//--- dac_host.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Device keeps shift and converter registers apart.
// - Device samples data on gated clock rise.
// - Words travel most significant bit first.
// - Clock rise or select rise shifts once.
// - Select and clock are interchangeable gates.
// - Select high makes device ignore clock.
// - Host raises select after each word.
// - Load low copies shift register asynchronously.
// - Converter register transparent while load low.
// - Host never shifts while load is low.
// - Clear low forces converter register zero.
// - Clear holds zeros; shift register untouched.
// - Host may pulse clear as reset.
// - Code maps linearly, one millivolt per step.
// - Host releases load before next word.
module dac_host #(
  parameter int WORD_BITS = dac_pkg::WORD_BITS,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Word stream from the user.
  input  wire logic [WORD_BITS-1:0] word_data,
  input  wire logic                 word_valid,
  output logic                      word_ready,
  // Clear request and status.
  input  wire logic                 clear_req,
  output logic                      busy,
  // Serial link to the converter.
  dac_link_if.host                  link
);
  import dac_pkg::*;

  initial begin
    if (WORD_BITS < 2 || WORD_BITS > 16) begin
      $error("dac_host: WORD_BITS must lie between 2 and 16");
    end
  end

  // The phase counter is four bits wide, so a slower pin timing or a faster
  // clock must not ask for more than sixteen cycles in one phase.
  initial begin
    if (CLK_HIGH_CYC > 16 || CLK_LOW_CYC > 16 ||
        SELECT_CYC > 16 || DESELECT_CYC > 16 ||
        LOAD_CYC > 16 || CLEAR_CYC > 16) begin
      $error("dac_host: a pin timing needs more cycles than the phase counter holds");
    end
  end

  host_state_t          state_ff;
  logic [3:0]           cnt_ff;
  logic [3:0]           bits_left_ff;
  logic [WORD_BITS-1:0] word_ff;
  logic                 clear_pend_ff;
  logic                 sclk_ff;
  logic                 sdi_ff;
  logic                 cs_n_ff;
  logic                 ld_n_ff;
  logic                 clr_n_ff;
  logic [WORD_BITS-1:0] buf_data;
  logic                 buf_valid;
  logic                 buf_pop;
  logic                 cnt_done;

  // The buffer stalls the user only when both entries wait behind a transfer.
  word_buffer #(
    .WIDTH (WORD_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .reset     (reset),
    .in_data   (word_data),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop)
  );

  // Words are taken only when idle, so load is always back high first.
  assign buf_pop  = (state_ff == ST_IDLE) && !clear_pend_ff && buf_valid;
  assign cnt_done = cnt_ff == 4'h0;

  assign link.sclk           = sclk_ff;
  assign link.serial_data_in = sdi_ff;
  assign link.chip_select_n  = cs_n_ff;
  assign link.load_strobe_n  = ld_n_ff;
  assign link.clear_n        = clr_n_ff;

  // A clear request is remembered; a new request wins over its own consumption.
  always_ff @(posedge clk) begin
    if (reset) begin
      clear_pend_ff <= 1'b0;
    end else if (clear_req) begin
      clear_pend_ff <= 1'b1;
    end else if (state_ff == ST_IDLE) begin
      clear_pend_ff <= 1'b0;
    end
  end

  // Sequencer: select, clock out bits, deselect, strobe load.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 4'h0;
      bits_left_ff <= 4'h0;
      word_ff      <= '0;
      sclk_ff      <= 1'b0;
      sdi_ff       <= 1'b0;
      cs_n_ff      <= 1'b1;
      ld_n_ff      <= 1'b1;
      clr_n_ff     <= 1'b1;
      busy         <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (clear_pend_ff) begin
            clr_n_ff <= 1'b0;
            cnt_ff   <= 4'(CLEAR_CYC - 1);
            busy     <= 1'b1;
            state_ff <= ST_CLEAR;
          end else if (buf_valid) begin
            word_ff      <= buf_data;
            bits_left_ff <= 4'(WORD_BITS - 1);
            cs_n_ff      <= 1'b0;
            cnt_ff       <= 4'(SELECT_CYC - 1);
            busy         <= 1'b1;
            state_ff     <= ST_SELECT;
          end else begin
            busy <= 1'b0;
          end
        end
        ST_SELECT: begin
          if (cnt_done) begin
            sdi_ff   <= word_ff[WORD_BITS-1];
            word_ff  <= {word_ff[WORD_BITS-2:0], 1'b0};
            cnt_ff   <= 4'(CLK_LOW_CYC - 1);
            state_ff <= ST_LOW;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_LOW: begin
          if (cnt_done) begin
            sclk_ff  <= 1'b1;
            cnt_ff   <= 4'(CLK_HIGH_CYC - 1);
            state_ff <= ST_HIGH;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_HIGH: begin
          if (!cnt_done) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else if (bits_left_ff == 4'h0) begin
            // Select rises while the clock is high, so it adds no shift.
            cs_n_ff  <= 1'b1;
            cnt_ff   <= 4'(DESELECT_CYC - 1);
            state_ff <= ST_DESELECT;
          end else begin
            sclk_ff      <= 1'b0;
            sdi_ff       <= word_ff[WORD_BITS-1];
            word_ff      <= {word_ff[WORD_BITS-2:0], 1'b0};
            bits_left_ff <= bits_left_ff - 4'h1;
            cnt_ff       <= 4'(CLK_LOW_CYC - 1);
            state_ff     <= ST_LOW;
          end
        end
        ST_DESELECT: begin
          if (cnt_done) begin
            sclk_ff  <= 1'b0;
            ld_n_ff  <= 1'b0;
            cnt_ff   <= 4'(LOAD_CYC - 1);
            state_ff <= ST_LOAD;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_LOAD: begin
          if (cnt_done) begin
            ld_n_ff  <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_CLEAR: begin
          if (cnt_done) begin
            clr_n_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          cs_n_ff  <= 1'b1;
          ld_n_ff  <= 1'b1;
          clr_n_ff <= 1'b1;
        end
      endcase
    end
  end
endmodule : dac_host
`default_nettype wire

//--- dac_device.sv
`timescale 1ns/1ns
`default_nettype none
module dac_device #(
  parameter int WORD_BITS = dac_pkg::WORD_BITS
) (
  // Link-side sampling clock and reset.
  input  wire logic                 link_clk,
  input  wire logic                 reset,
  // Serial pins from the host.
  dac_link_if.device                link,
  // Output code in millivolts.
  output logic      [WORD_BITS-1:0] analog_output
);
  import dac_pkg::*;

  initial begin
    if (WORD_BITS != 12 || MV_PER_LSB != 1 || FULL_SCALE_MV != (1 << WORD_BITS) - 1) begin
      $error("dac_device: scale needs a 12-bit word at one millivolt per step");
    end
  end

  logic [4:0]           meta_ff;
  logic [4:0]           sync_ff;
  logic                 gate_d_ff;
  logic [WORD_BITS-1:0] shift_ff;
  logic                 sclk_s;
  logic                 sdi_s;
  logic                 cs_n_s;
  logic                 ld_n_s;
  logic                 clr_n_s;
  logic                 gate;
  logic                 shift_en;
  logic                 rst_meta_ff;
  logic                 rst_sync_ff;

  // Reset is released in the host's clock domain, so it is retimed here first.
  always_ff @(posedge link_clk) begin
    rst_meta_ff <= reset;
    rst_sync_ff <= rst_meta_ff;
  end

  // All pins cross together, so data keeps its place against the clock edge.
  always_ff @(posedge link_clk) begin
    if (rst_sync_ff) begin
      meta_ff <= 5'h1d;
      sync_ff <= 5'h1d;
    end else begin
      meta_ff <= {link.clear_n, link.load_strobe_n, link.chip_select_n,
                  link.serial_data_in, link.sclk};
      sync_ff <= meta_ff;
    end
  end

  assign {clr_n_s, ld_n_s, cs_n_s, sdi_s, sclk_s} = sync_ff;

  // Either input rising while the other is low gives one shift.
  assign gate     = sclk_s | cs_n_s;
  assign shift_en = gate && !gate_d_ff;

  always_ff @(posedge link_clk) begin
    if (rst_sync_ff) begin
      gate_d_ff <= 1'b1;
    end else begin
      gate_d_ff <= gate;
    end
  end

  // Oldest bit falls off the top, so the first bit ends as the MSB.
  always_ff @(posedge link_clk) begin
    if (rst_sync_ff) begin
      shift_ff <= '0;
    end else if (shift_en) begin
      shift_ff <= {shift_ff[WORD_BITS-2:0], sdi_s};
    end
  end

  // Converter register: clear dominates, load is level sensitive.
  always_ff @(posedge link_clk) begin
    if (rst_sync_ff) begin
      analog_output <= DAC_RESET_CODE;
    end else if (!clr_n_s) begin
      analog_output <= DAC_RESET_CODE;
    end else if (!ld_n_s) begin
      analog_output <= shift_ff;
    end else begin
      analog_output <= analog_output;
    end
  end
endmodule : dac_device
`default_nettype wire

//--- dac_link_props.sv
`timescale 1ns/1ns
`default_nettype none
module dac_link_props (
  // Host clock domain.
  input wire logic clk,
  input wire logic reset,
  // Link pins as the host drives them.
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic chip_select_n,
  input wire logic load_strobe_n,
  input wire logic clear_n
);
  logic [4:0] rises_ff;
  logic       sclk_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Counts clock rises in a frame, so a short or long word shows at deselect.
  always_ff @(posedge clk) begin
    sclk_ff <= reset ? 1'b0 : sclk;
    if (reset || chip_select_n) begin
      rises_ff <= 5'h00;
    end else if (sclk && !sclk_ff) begin
      rises_ff <= rises_ff + 5'h01;
    end
  end

  a_frame_twelve: assert property ($rose(chip_select_n) |-> rises_ff == 5'h0c)
    else $error("frame ended without twelve clock rises");
  a_rise_selected: assert property ($rose(sclk) |-> !chip_select_n)
    else $error("clock rose while deselected");
  a_data_steady: assert property ($rose(sclk) |-> $stable(serial_data_in))
    else $error("data moved at the clock rise");
  a_load_follows: assert property ($rose(chip_select_n) |=> $fell(load_strobe_n))
    else $error("load did not follow deselect");
  a_load_idle: assert property ($fell(load_strobe_n) |-> chip_select_n && !sclk)
    else $error("load began inside a frame");
  a_load_released: assert property ($fell(load_strobe_n) |=> load_strobe_n)
    else $error("load held low too long");
  a_no_shift_load: assert property (!load_strobe_n |-> chip_select_n && !$rose(sclk))
    else $error("shift while load low");
  a_clear_pulse: assert property ($fell(clear_n) |=> clear_n)
    else $error("clear held low too long");
  a_clear_idle: assert property (!clear_n |-> chip_select_n && load_strobe_n)
    else $error("clear overlapped a frame or load");
endmodule : dac_link_props
`default_nettype wire

//--- serial_dac_input_logic_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module serial_dac_input_logic_tb_top;
  import dac_pkg::*;
  logic                 clk;
  logic                 link_clk;
  logic                 reset;
  logic [WORD_BITS-1:0] word_data;
  logic                 word_valid;
  logic                 word_ready;
  logic                 clear_req;
  logic                 busy;
  logic [WORD_BITS-1:0] out_a;
  logic [WORD_BITS-1:0] out_b;
  logic                 saw_full;
  int                   fail_count;
  int                   num_checks;
  int                   cycles;
  logic [11:0]          codes [4] = '{12'hfff, 12'h800, 12'h001, 12'ha5c};
  logic [13:0]          long_word = 14'h2a5c;

  dac_link_if lk ();
  dac_link_if lk2 ();
  dac_host dac_host_inst (.clk(clk), .reset(reset), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready), .clear_req(clear_req),
    .busy(busy), .link(lk.host));
  dac_device dac_device_inst (.link_clk(link_clk), .reset(reset), .link(lk.device),
    .analog_output(out_a));
  // Second device driven pin by pin, to reach cases the host never makes.
  dac_device dac_device_inst2 (.link_clk(link_clk), .reset(reset), .link(lk2.device),
    .analog_output(out_b));
  dac_link_props dac_link_props_inst (.clk(clk), .reset(reset), .sclk(lk.sclk),
    .serial_data_in(lk.serial_data_in), .chip_select_n(lk.chip_select_n),
    .load_strobe_n(lk.load_strobe_n), .clear_n(lk.clear_n));

  // Host clock and a link clock of unrelated period.
  always #25 clk = ~clk;
  always #6 link_clk = ~link_clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_code(input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t exp %h got %h", $time, exp, got);
    end
  endtask : check_code

  task automatic check_bit(input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t exp %h got %h", $time, exp, got);
    end
  endtask : check_bit

  // Offers a word and holds it until taken; valid stays up for the next call.
  task automatic push(input logic [11:0] w);
    word_data  = w;
    word_valid = 1'b1;
    while (word_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(negedge clk);
    end
    @(negedge clk);
  endtask : push

  // Waits for the host to stay idle, so the load has reached the converter.
  task automatic settle;
    int k;
    k = 0;
    while (k < 4) begin
      @(negedge clk);
      k = (busy === 1'b0) ? k + 1 : 0;
    end
  endtask : settle

  // Pin levels for the second device, each held well over two link periods.
  task automatic pins(input logic [4:0] v);
    {lk2.chip_select_n, lk2.sclk, lk2.serial_data_in, lk2.load_strobe_n, lk2.clear_n} <= v;
    repeat (2) @(negedge clk);
  endtask : pins

  task automatic bang(input logic b, input logic via_cs);
    pins({2'b00, b, 2'b11});
    pins({via_cs, !via_cs, b, 2'b11});
  endtask : bang

  // Ends the run if something hangs; the tests need about four hundred cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    clk = 1'b0;
    link_clk = 1'b0;
    reset = 1'b1;
    word_data = 12'h000;
    word_valid = 1'b0;
    clear_req = 1'b0;
    saw_full = 1'b0;
    fail_count = 0;
    num_checks = 0;
    cycles = 0;
    {lk2.chip_select_n, lk2.sclk, lk2.serial_data_in, lk2.load_strobe_n, lk2.clear_n} <= 5'h13;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    check_code(12'h000, out_a);
    check_bit(1'b1, lk.chip_select_n);
    check_bit(1'b1, lk.load_strobe_n);
    check_bit(1'b1, lk.clear_n);
    check_bit(1'b0, busy);
    check_bit(1'b1, word_ready);
    $display("test reset finished");
    foreach (codes[i]) begin
      push(codes[i]);
      word_valid = 1'b0;
      settle();
      check_code(codes[i], out_a);
    end
    $display("test single words finished");
    // Four words at once must hit the full buffer; the last one wins.
    saw_full = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      push(codes[i]);
    end
    word_valid = 1'b0;
    settle();
    check_bit(1'b1, saw_full);
    check_code(codes[0], out_a);
    $display("test back to back finished");
    // A clear asked for mid-word waits for the word, then zeroes the output.
    push(12'h123);
    word_valid = 1'b0;
    clear_req = 1'b1;
    @(negedge clk);
    clear_req = 1'b0;
    settle();
    check_code(12'h000, out_a);
    $display("test clear finished");
    for (int i = 13; i >= 0; i--) begin
      bang(long_word[i], 1'b0);
    end
    pins({2'b10, ~long_word[0], 2'b11});
    check_code(12'h000, out_b);
    pins(5'h11);
    check_code(12'ha5c, out_b);
    pins(5'h13);
    // Clock rises while deselected must not shift; select rises must.
    pins(5'h1f);
    pins(5'h17);
    pins(5'h1f);
    pins(5'h17);
    for (int i = 5; i >= 0; i--) begin
      bang(i < 3, 1'b1);
    end
    pins(5'h11);
    pins(5'h13);
    check_code(12'h707, out_b);
    pins(5'h12);
    check_code(12'h000, out_b);
    pins(5'h13);
    check_code(12'h000, out_b);
    // Load low while clear is low must still leave zeros.
    pins(5'h10);
    check_code(12'h000, out_b);
    pins(5'h13);
    check_code(12'h000, out_b);
    pins(5'h11);
    pins(5'h13);
    check_code(12'h707, out_b);
    $display("test far device finished");
    report_and_stop();
  end
endmodule : serial_dac_input_logic_tb_top
`default_nettype wire
